// ===== sop_defs.vh
`ifndef SOP_DEFS_VH
`define SOP_DEFS_VH

// Register addresses on the configuration port.
`define SOP_ADDR_CTRL      6'h18
`define SOP_ADDR_FMT       6'h19
`define SOP_ADDR_RATE      6'h1a

// Reset values.
`define SOP_CTRL_RST       8'h12
`define SOP_FMT_RST        8'h07
`define SOP_RATE_RST       4'h1

// Control register fields.
`define SOP_CTRL_ALTERNATE_GAIN_BYTES      7
`define SOP_CTRL_EMBED_GAIN_BYTES      6
`define SOP_CTRL_EFS       5
`define SOP_CTRL_SYNC_TRISTATE      4
`define SOP_CTRL_SYNC_INVERT      3
`define SOP_CTRL_LATE_SYNC      2
`define SOP_CTRL_BITCLK_TRISTATE      1
`define SOP_CTRL_BITCLK_INVERT      0

// Format register fields.
`define SOP_FMT_4WIRE      7
`define SOP_FMT_DW         3
`define SOP_FMT_DS_HI      2
`define SOP_FMT_DS_LO      0
`define SOP_FMT_MASK       8'h8f

// Frame geometry in bits.
`define SOP_LEN_16         7'h20
`define SOP_LEN_24         7'h30
`define SOP_LEN_PAIR       7'h10
`define SOP_LEN_ALT        7'h08
`define SOP_EFS_MIN_IDLE   4'ha
`define SOP_IDLE_MAX       4'hf

// Saturating counter limit.
`define SOP_RCNT_MAX       2'h3

// Engine states.
`define SOP_ST_IDLE        2'h0
`define SOP_ST_SYNC        2'h1
`define SOP_ST_DATA        2'h2

`endif

// ===== sop_bitclk_div.v
`timescale 1ns/1ns
`include "sop_defs.vh"

module sop_bitclk_div (
  // Clock and reset
  input  wire       i_core_clk,
  input  wire       i_rstn,
  // Divisor
  input  wire [3:0] i_div,
  // Bit timing
  output wire       o_tick,
  output wire       o_level
);

  reg  [3:0] cnt_r;
  wire [3:0] div_eff;
  wire [3:0] half;

  // A divisor of zero is treated as one so the port never stalls.
  assign div_eff = (i_div == 4'h0) ? 4'h1 : i_div;
  // Half period rounded up, built without a carry so a divisor of fifteen still fits.
  assign half    = {1'b0, div_eff[3:1]} + {3'h0, div_eff[0]};
  assign o_tick  = (cnt_r == 4'h0);
  // With a divisor of one the level stays high: a flop cannot toggle at the full clock rate.
  assign o_level = (cnt_r < half);

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 4'h0;
    end else if (cnt_r >= div_eff - 4'h1) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

endmodule // sop_bitclk_div

// ===== sop_rst_count.v
`timescale 1ns/1ns
`include "sop_defs.vh"

module sop_rst_count (
  // Clock and reset
  input  wire       i_core_clk,
  input  wire       i_rstn,
  // Events
  input  wire       i_event,
  input  wire       i_clear,
  // Count
  output wire [1:0] o_count
);

  reg [1:0] cnt_r;

  assign o_count = cnt_r;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 2'h0;
    end else if (i_clear) begin
      // An event in the clearing cycle is kept as the first of the next report.
      cnt_r <= {1'b0, i_event};
    end else if (i_event && cnt_r != `SOP_RCNT_MAX) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

endmodule // sop_rst_count

// ===== sop_frame_port.v
// Function
// - Status bytes follow I and Q only when embed_gain_bytes is set.
// - First status byte is the 8-bit attenuation code, 0 none, 255 is 24 dB.
// - Second status byte packs 2-bit reset count with 6-bit signal strength.
// - Reset count counts modulator resets since last report, saturating at 3.
// - Signal strength is a linear amplitude estimate, 60 meaning full scale.
// - Paired mode sends both status bytes each frame as one 16-bit word.
// - Alternating mode sends one status byte per frame, alternating the two bytes.
// - Alternating mode forces attenuation LSB to 0 and reset/strength LSB to 1.
// - Embedded framing wraps bytes in low start, high stop, frames end with 10 highs.
// - Embedded framing holds frame sync low or three-stated per sync_tristate.
// - Sync invert, late sync, clock invert and clock three-state; late ignored embedded.
// - Word width select picks 16 or 24 bits; alias flag forces 16 bits.
// - Four-wire readback copies register read data onto aux_data_out; resets 0.
// - Bit clock is core clock divided by the 4-bit divisor, reset to 1.
// - After the payload the line idles high until the next frame.
// - Dedicated-sync payload is 32/48/40 or 48/64/56 bits by width and mode.
// - Default mode sends a one-bit sync pulse then data on rising clock edges.
// - I word then Q word, MSB first, two's complement, 16 or 24 bits.
// - One frame starts per decimated output sample, unless a newer sample replaces it while it waits.
`timescale 1ns/1ns
`include "sop_defs.vh"

module sop_frame_port (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_rstn,
  // Register access from the configuration port
  input  wire        i_reg_wr,
  input  wire [5:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  output wire [7:0]  o_reg_rdata,
  input  wire        i_cfg_rd_bit,
  // Decimated samples and status
  input  wire        i_sample_valid,
  input  wire [23:0] i_i_word,
  input  wire [23:0] i_q_word,
  input  wire [7:0]  i_atten_code,
  input  wire        i_mod_reset_evt,
  input  wire [5:0]  i_signal_strength,
  input  wire        i_alternate_flag_alias,
  // Serial pins
  output wire        o_bit_clock_out,
  output wire        o_bit_clock_oe,
  output wire        o_frame_sync_out,
  output wire        o_frame_sync_oe,
  output wire        o_serial_data_out,
  output wire        o_aux_data_out,
  output wire [2:0]  o_drive_strength_sel
);

  // Wraps up to eight payload bytes in start and stop bits, left justified.
  function [79:0] efs_wrap;
    input [63:0] pay;
    integer k;
    begin
      efs_wrap = {80{1'b1}};
      for (k = 0; k < 8; k = k + 1) begin
        efs_wrap[79 - 10 * k]        = 1'b0;
        efs_wrap[78 - 10 * k -: 8]   = pay[63 - 8 * k -: 8];
        efs_wrap[70 - 10 * k]        = 1'b1;
      end
    end
  endfunction

  // True when this cycle writes the register at the given address.
  function wr_hit;
    input       wr;
    input [5:0] addr;
    input [5:0] target;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // Register file.
  reg  [7:0]  ctrl_r;
  reg  [7:0]  fmt_r;
  reg  [3:0]  rate_r;
  reg  [7:0]  rdata_r;
  reg  [7:0]  rdata_nxt;

  // Framing state.
  reg  [1:0]  state_r;
  reg  [79:0] pend_r;
  reg  [6:0]  pend_len_r;
  reg         pend_v_r;
  reg  [79:0] shreg_r;
  reg  [6:0]  rem_r;
  reg  [3:0]  idle_r;
  reg         alt_sel_r;
  reg         data_r;
  reg         fs_r;
  reg         clk_pin_r;
  reg         fs_pin_r;
  reg         aux_r;

  reg  [63:0] pay;
  reg  [6:0]  len;
  reg  [15:0] opt;

  wire        tick;
  wire        level;
  wire [1:0]  rcnt;
  wire        wide;
  wire        embedded_sync_enable;
  wire        embed_gain_bytes;
  wire        alternate_gain_bytes;
  wire        late;
  wire [7:0]  atten_b;
  wire [7:0]  stat_b;
  wire        rcnt_clr;
  wire        idle_ok;
  wire [79:0] frame_bits;
  wire [6:0]  frame_len;
  wire        frame_go;
  wire        fs_nxt;

  assign embedded_sync_enable  = ctrl_r[`SOP_CTRL_EFS];
  assign embed_gain_bytes = ctrl_r[`SOP_CTRL_EMBED_GAIN_BYTES];
  assign alternate_gain_bytes = ctrl_r[`SOP_CTRL_ALTERNATE_GAIN_BYTES];
  assign late = ctrl_r[`SOP_CTRL_LATE_SYNC] & ~embedded_sync_enable;
  assign wide = fmt_r[`SOP_FMT_DW] & ~i_alternate_flag_alias;

  // Rate one leaves the bit clock high, so a host needs a divisor of two or more.
  sop_bitclk_div u_div (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_div      (rate_r),
    .o_tick     (tick),
    .o_level    (level)
  );

  // The count is consumed when the byte carrying it is captured for a frame.
  assign rcnt_clr = i_sample_valid & embed_gain_bytes & (~alternate_gain_bytes | alt_sel_r);

  sop_rst_count u_rcnt (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_event    (i_mod_reset_evt),
    .i_clear    (rcnt_clr),
    .o_count    (rcnt)
  );

  assign atten_b = i_atten_code;
  assign stat_b  = {i_signal_strength, rcnt};

  // Payload assembly, I then Q, MSB first.
  always @* begin
    if (!embed_gain_bytes) begin
      opt = 16'h0000;
    end else if (alternate_gain_bytes) begin
      opt = alt_sel_r ? {stat_b[7:1], 1'b1, 8'h00} : {atten_b[7:1], 1'b0, 8'h00};
    end else begin
      opt = {atten_b, stat_b};
    end
    if (wide) begin
      pay = {i_i_word, i_q_word, opt};
      len = `SOP_LEN_24;
    end else begin
      pay = {i_i_word[15:0], i_q_word[15:0], opt, 16'h0000};
      len = `SOP_LEN_16;
    end
    if (embed_gain_bytes) begin
      len = len + (alternate_gain_bytes ? `SOP_LEN_ALT : `SOP_LEN_PAIR);
    end
  end

  assign frame_bits = embedded_sync_enable ? efs_wrap(pay) : {pay, 16'hffff};
  assign frame_len  = embedded_sync_enable ? len + (len >> 2) : len;
  assign idle_ok    = !embedded_sync_enable || (idle_r >= `SOP_EFS_MIN_IDLE);

  // The sync pin is loaded from the engine's next value, so it leaves the same
  // flop stage as the data bit and the rising bit clock.
  assign frame_go = tick && (state_r == `SOP_ST_IDLE) && pend_v_r && idle_ok;
  assign fs_nxt   = tick ? frame_go : fs_r;

  // Register writes and alternation bookkeeping.
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r    <= `SOP_CTRL_RST;
      fmt_r     <= `SOP_FMT_RST;
      rate_r    <= `SOP_RATE_RST;
      alt_sel_r <= 1'b0;
    end else begin
      if (wr_hit(i_reg_wr, i_reg_addr, `SOP_ADDR_CTRL)) begin
        ctrl_r <= i_reg_wdata;
      end
      if (wr_hit(i_reg_wr, i_reg_addr, `SOP_ADDR_FMT)) begin
        fmt_r <= i_reg_wdata & `SOP_FMT_MASK;
      end
      if (wr_hit(i_reg_wr, i_reg_addr, `SOP_ADDR_RATE)) begin
        rate_r <= i_reg_wdata[3:0];
      end
      if (i_sample_valid) begin
        alt_sel_r <= embed_gain_bytes & alternate_gain_bytes & ~alt_sel_r;
      end
    end
  end

  always @* begin
    case (i_reg_addr)
      `SOP_ADDR_CTRL: rdata_nxt = ctrl_r;
      `SOP_ADDR_FMT:  rdata_nxt = fmt_r;
      `SOP_ADDR_RATE: rdata_nxt = {4'h0, rate_r};
      default:        rdata_nxt = 8'h00;
    endcase
  end

  // Frame engine; a captured sample waits for the next bit boundary.
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r    <= `SOP_ST_IDLE;
      pend_r     <= {80{1'b1}};
      pend_len_r <= 7'h00;
      pend_v_r   <= 1'b0;
      shreg_r    <= {80{1'b1}};
      rem_r      <= 7'h00;
      idle_r     <= 4'h0;
      data_r     <= 1'b1;
      fs_r       <= 1'b0;
    end else begin
      if (tick) begin
        case (state_r)
          `SOP_ST_IDLE: begin
            if (pend_v_r && idle_ok) begin
              if (embedded_sync_enable || late) begin
                // Late sync rides on the first data bit.
                data_r  <= pend_r[79];
                shreg_r <= {pend_r[78:0], 1'b1};
                rem_r   <= pend_len_r - 7'h01;
                fs_r    <= ~embedded_sync_enable;
                state_r <= `SOP_ST_DATA;
              end else begin
                shreg_r <= pend_r;
                rem_r   <= pend_len_r;
                fs_r    <= 1'b1;
                data_r  <= 1'b1;
                state_r <= `SOP_ST_SYNC;
              end
            end else begin
              data_r <= 1'b1;
              fs_r   <= 1'b0;
              if (idle_r != `SOP_IDLE_MAX) begin
                idle_r <= idle_r + 4'h1;
              end
            end
          end
          `SOP_ST_SYNC, `SOP_ST_DATA: begin
            fs_r <= 1'b0;
            if (rem_r == 7'h00) begin
              data_r  <= 1'b1;
              idle_r  <= 4'h1;
              state_r <= `SOP_ST_IDLE;
            end else begin
              data_r  <= shreg_r[79];
              shreg_r <= {shreg_r[78:0], 1'b1};
              rem_r   <= rem_r - 7'h01;
              state_r <= `SOP_ST_DATA;
            end
          end
          default: begin
            state_r <= `SOP_ST_IDLE;
          end
        endcase
      end
      // A new sample wins over the start that consumes the old one.
      if (i_sample_valid) begin
        pend_r     <= frame_bits;
        pend_len_r <= frame_len;
        pend_v_r   <= 1'b1;
      end else if (tick && state_r == `SOP_ST_IDLE && idle_ok) begin
        pend_v_r   <= 1'b0;
      end
    end
  end

  // Pin stage; every pin leaves a flop so all edges stay aligned.
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_pin_r <= 1'b0;
      fs_pin_r  <= 1'b0;
      aux_r     <= 1'b0;
      rdata_r   <= 8'h00;
    end else begin
      clk_pin_r <= level ^ ctrl_r[`SOP_CTRL_BITCLK_INVERT];
      fs_pin_r  <= embedded_sync_enable ? 1'b0 : (fs_nxt ^ ctrl_r[`SOP_CTRL_SYNC_INVERT]);
      aux_r     <= fmt_r[`SOP_FMT_4WIRE] & i_cfg_rd_bit;
      rdata_r   <= rdata_nxt;
    end
  end

  assign o_bit_clock_out      = clk_pin_r;
  assign o_bit_clock_oe       = ~ctrl_r[`SOP_CTRL_BITCLK_TRISTATE];
  assign o_frame_sync_out     = fs_pin_r;
  assign o_frame_sync_oe      = ~ctrl_r[`SOP_CTRL_SYNC_TRISTATE];
  assign o_serial_data_out    = data_r;
  assign o_aux_data_out       = aux_r;
  assign o_reg_rdata          = rdata_r;
  assign o_drive_strength_sel = fmt_r[`SOP_FMT_DS_HI:`SOP_FMT_DS_LO];

endmodule // sop_frame_port

// ===== sop_frame_port_properties.sv
`timescale 1ns/1ns
`include "sop_defs.vh"
module sop_frame_port_properties (
  // Clock and reset
  input wire       i_core_clk,
  input wire       i_rstn,
  // Register port
  input wire       i_reg_wr,
  input wire [5:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] o_reg_rdata,
  input wire       i_cfg_rd_bit,
  // Serial pins
  input wire       o_bit_clock_out,
  input wire       o_bit_clock_oe,
  input wire       o_frame_sync_out,
  input wire       o_frame_sync_oe,
  input wire       o_serial_data_out,
  input wire       o_aux_data_out
);
  reg  [7:0] ctrl_r, ctrl_d_r, fmt_r, per_r;
  reg  [3:0] rate_r;
  reg        bc_d_r, seen_r;
  wire       bc = o_bit_clock_out ^ ctrl_d_r[0];
  wire       fsa = o_frame_sync_out ^ ctrl_d_r[3];
  wire       rise = bc & ~bc_d_r;
  wire       fw = fmt_r[7];
  wire       emb = ctrl_r[5];
  wire [7:0] rd = (i_reg_addr == `SOP_ADDR_CTRL) ? ctrl_r : (i_reg_addr == `SOP_ADDR_FMT) ? fmt_r :
                  (i_reg_addr == `SOP_ADDR_RATE) ? {4'h0, rate_r} : 8'h00;
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= `SOP_CTRL_RST;
      ctrl_d_r <= `SOP_CTRL_RST;
      fmt_r <= `SOP_FMT_RST;
      rate_r <= `SOP_RATE_RST;
      bc_d_r <= 1'b0;
      seen_r <= 1'b0;
      per_r <= 8'h00;
    end else begin
      if (i_reg_wr && i_reg_addr == `SOP_ADDR_CTRL) ctrl_r <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == `SOP_ADDR_FMT) fmt_r <= i_reg_wdata & `SOP_FMT_MASK;
      if (i_reg_wr && i_reg_addr == `SOP_ADDR_RATE) rate_r <= i_reg_wdata[3:0];
      ctrl_d_r <= ctrl_r;
      bc_d_r <= bc;
      per_r <= rise ? 8'h01 : per_r + 8'h01;
      // A write may bend the running bit period, so period checks restart after one.
      seen_r <= ~i_reg_wr & (seen_r | rise);
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  AST_RDATA: assert property ($past(i_rstn) |-> o_reg_rdata == $past(rd))
    else $error("read data wrong");
  AST_CLK_OE: assert property (o_bit_clock_oe == !ctrl_r[1])
    else $error("clock enable wrong");
  AST_FS_OE: assert property (o_frame_sync_oe == !ctrl_r[4])
    else $error("sync enable wrong");
  AST_AUX: assert property (o_aux_data_out == ($past(fw) & $past(i_cfg_rd_bit)))
    else $error("aux line wrong");
  AST_PERIOD: assert property (rise && seen_r |-> per_r == {4'h0, rate_r})
    else $error("bit period wrong");
  AST_EDGE: assert property (($changed(o_serial_data_out) || $changed(fsa)) && rate_r > 4'h1 &&
    ctrl_r == $past(ctrl_r, 2) |-> rise) else $error("pin moved off the clock edge");
  AST_SYNC_ONE: assert property (rise && $past(fsa) && !emb |-> !fsa)
    else $error("sync pulse too long");
  AST_EMB_FS: assert property (emb && $past(emb, 2) && !ctrl_r[3] |-> !o_frame_sync_out)
    else $error("sync active in embedded mode");
  cover property (rise && fsa);
  cover property (emb && $fell(o_serial_data_out));
  cover property (fw && o_aux_data_out);
endmodule // sop_frame_port_properties
bind sop_frame_port sop_frame_port_properties u_props (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_cfg_rd_bit(i_cfg_rd_bit), .o_bit_clock_out(o_bit_clock_out), .o_bit_clock_oe(o_bit_clock_oe),
  .o_frame_sync_out(o_frame_sync_out), .o_frame_sync_oe(o_frame_sync_oe),
  .o_serial_data_out(o_serial_data_out), .o_aux_data_out(o_aux_data_out));

// ===== sop_host_rx.sv
`timescale 1ns/1ns
module sop_host_rx (
  // Serial pins
  input  wire        i_bclk,
  input  wire        i_fs,
  input  wire        i_data,
  // Receiver setup
  input  wire        i_embedded,
  input  wire        i_late,
  input  wire [6:0]  i_nbits,
  // Received frame
  output reg  [63:0] o_frame,
  output reg         o_stop_err,
  output reg         o_done
);
  reg [6:0] cnt_r;
  reg [3:0] pos_r;
  reg       act_r;
  initial begin
    {o_frame, o_stop_err, o_done, cnt_r, pos_r, act_r} = 0;
  end
  // Bits are taken on the falling clock, half a period after they launch.
  always @(negedge i_bclk) begin
    o_done <= 1'b0;
    if (!i_embedded && i_fs && !i_late) begin
      act_r <= 1'b1;
      cnt_r <= 7'h00;
    end else if (i_embedded && pos_r == 4'h0) begin
      pos_r <= {3'h0, ~i_data};
    end else if (i_embedded && pos_r == 4'h9) begin
      o_stop_err <= o_stop_err | ~i_data;
      pos_r <= 4'h0;
    end else if (act_r || i_embedded || i_fs) begin
      // A late sync marks the first data bit itself.
      o_frame <= {o_frame[62:0], i_data};
      cnt_r <= ((i_fs && !i_embedded) ? 7'h00 : cnt_r) + 7'h01;
      act_r <= 1'b1;
      pos_r <= pos_r + {3'h0, i_embedded};
      if (((i_fs && !i_embedded) ? 7'h00 : cnt_r) + 7'h01 == i_nbits) begin
        act_r <= 1'b0;
        cnt_r <= 7'h00;
        o_done <= 1'b1;
      end
    end
  end
endmodule // sop_host_rx

// ===== sop_frame_port_tb_top.sv
`timescale 1ns/1ns
`include "sop_defs.vh"
module sop_frame_port_tb_top;
  localparam [71:0] CTL = 72'h40_e024_c040_0dc0_4000;
  localparam [71:0] FMT = 72'h88_0800_0808_0800_0000;
  reg clk = 1'b0, rstn = 1'b0, wr = 1'b0, sv = 1'b0, ev = 1'b0, cfg = 1'b0, al = 1'b0;
  reg w24, pr, alt;
  reg [5:0] ad = 6'h00, st = 6'h00;
  reg [6:0] nb = 7'h20;
  reg [7:0] wd = 8'h00, at = 8'h00, ct = 8'h00, sb;
  reg [23:0] iw = 24'h00_0000, qw = 24'h00_0000;
  reg [31:0] seed = 32'h0000_6047;
  reg [63:0] msk, v;
  reg [63:0] eq[$];
  wire bclk, boe, fs, dout, done, serr;
  wire [7:0] rdata;
  wire [2:0] ds;
  wire [63:0] hf;
  integer error_cnt = 0, comparisons = 0, cyc = 0, m, f, k, cm;
  sop_frame_port DUT (.i_core_clk(clk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_addr(ad), .i_reg_wdata(wd),
    .o_reg_rdata(rdata), .i_cfg_rd_bit(cfg), .i_sample_valid(sv), .i_i_word(iw), .i_q_word(qw),
    .i_atten_code(at), .i_mod_reset_evt(ev), .i_signal_strength(st), .i_alternate_flag_alias(al),
    .o_bit_clock_out(bclk), .o_bit_clock_oe(boe), .o_frame_sync_out(fs), .o_frame_sync_oe(),
    .o_serial_data_out(dout), .o_aux_data_out(), .o_drive_strength_sel(ds));
  // A three-stated clock floats to its pull-up level at the host.
  sop_host_rx u_host (.i_bclk(boe ? bclk ^ ct[0] : 1'b1), .i_fs(fs ^ ct[3]), .i_data(dout),
    .i_embedded(ct[5]), .i_late(ct[2]), .i_nbits(nb), .o_frame(hf), .o_stop_err(serr), .o_done(done));
  always #5 clk = ~clk;
  function [31:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  task check(input string nm, input [63:0] seen, input [63:0] ex);
    begin
      comparisons = comparisons + 1;
      if (seen !== ex) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task wr_reg(input [5:0] a, input [7:0] d);
    begin
      @(negedge clk);
      wr = 1'b1;
      ad = a;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
    end
  endtask
  task rd(input [5:0] a, input [7:0] e);
    begin
      @(negedge clk);
      ad = a;
      repeat (2) @(negedge clk);
      check("register", rdata, e);
    end
  endtask
  always @(negedge clk) cfg <= ^rnd();
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  end
  always @(posedge done) begin
    if (eq.size() == 0) check("extra frame", 64'h1, 64'h0);
    else check("frame", hf & msk, eq.pop_front());
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    rd(`SOP_ADDR_CTRL, `SOP_CTRL_RST);
    rd(`SOP_ADDR_FMT, `SOP_FMT_RST);
    rd(`SOP_ADDR_RATE, {4'h0, `SOP_RATE_RST});
    rd(6'h00, 8'h00);
    wr_reg(`SOP_ADDR_FMT, 8'hff);
    rd(`SOP_ADDR_FMT, 8'h8f);
    check("drive strength", ds, 64'h7);
    wr_reg(`SOP_ADDR_RATE, 8'hf5);
    rd(`SOP_ADDR_RATE, 8'h05);
    for (m = 0; m < 9; m = m + 1) begin
      // The link settings change only right after reset, while the reset divisor of one holds the bit clock pin still.
      rstn = 1'b0;
      repeat (8) @(negedge clk);
      ct = CTL[8*m +: 8];
      rstn = 1'b1;
      al = (m == 8);
      w24 = FMT[8*m+3] & ~al;
      pr = ct[6] & ~ct[7];
      alt = ct[6] & ct[7];
      nb = (w24 ? 7'h30 : 7'h20) + (pr ? 7'h10 : 7'h00) + (alt ? 7'h08 : 7'h00);
      msk = ~({64{1'b1}} << nb);
      cm = 0;
      wr_reg(`SOP_ADDR_CTRL, ct);
      wr_reg(`SOP_ADDR_FMT, FMT[8*m +: 8]);
      check("drive strength", ds, FMT[8*m +: 3]);
      wr_reg(`SOP_ADDR_RATE, 8'h02 + 8'(rnd() % 3));
      for (f = 0; f < 2; f = f + 1) begin
        k = rnd() % 6;
        repeat (k) begin
          @(negedge clk) ev = 1'b1;
          @(negedge clk) ev = 1'b0;
        end
        @(negedge clk);
        cm = cm + k;
        iw = 24'(rnd());
        qw = 24'(rnd());
        at = 8'(rnd());
        st = 6'(rnd());
        sb = {st, (cm > 3) ? 2'h3 : cm[1:0]};
        if (pr || (alt && f == 1)) cm = 0;
        v = w24 ? {16'h0000, iw, qw} : {32'h0000_0000, iw[15:0], qw[15:0]};
        if (pr) v = {v[47:0], at, sb};
        if (alt) v = {v[55:0], (f == 1) ? {sb[7:1], 1'b1} : {at[7:1], 1'b0}};
        eq.push_back(v);
        sv = 1'b1;
        @(negedge clk) sv = 1'b0;
        // Each frame drains before the next sample, so every frame fits its slot.
        for (k = 0; k < 3000 && eq.size() > 0; k = k + 1) @(negedge clk);
      end
    end
    check("pending frames", eq.size(), 0);
    check("stop bits", serr, 0);
    conclude;
  end
endmodule // sop_frame_port_tb_top
